// file: hdl/pfs_cfg.svh
// Operation
// - The motor is driven in 2-2 phase excitation, two phases active in every step.
// - A step period or excitation longer than 2.0 ms needs limited current or no excitation.
// - A restart from standstill first excites one step with the phase of the stopping step.
// - After a restart from standstill, backlash is taken up by 10 lines back then 10 forward, or 4 forward.
// - Ordinary paper feed steps at 640 pps, a period of 1.56 ms.
// - Automatic paper feed steps with a period of 8 ms.
// - No step is made without paper except in automatic feed or with the head raised.
// - The motor is de-excited when no feed runs and never runs longer than 10 minutes.
// - The print step rate can be changed at run time.
// - A print period longer than the standard one selects reduced excitation.
// - Forward feed walks A,B,A-bar,B-bar through LLHH, LHHL, HHLL, HLLH; reverse walks back.
// - The excitation gate is high to excite the motor and low to leave it non-excited.
// - A feed ends with one stopping step repeating the last pattern before de-excitation.
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH
`define PFS_CLK_HZ 200000000
`define PFS_CYC_PER_US (`PFS_CLK_HZ / 1000000)
`define PFS_DOT_UM 125
`define PFS_FEED_PERIOD_US 1560
`define PFS_FEED_CYC (`PFS_FEED_PERIOD_US * `PFS_CYC_PER_US)
`define PFS_AUTO_PERIOD_US 8000
`define PFS_AUTO_CYC (`PFS_AUTO_PERIOD_US * `PFS_CYC_PER_US)
`define PFS_SLOW_PPS 125
`define PFS_SLOW_CYC (`PFS_CLK_HZ / `PFS_SLOW_PPS)
`define PFS_HEAT_US 2000
`define PFS_HEAT_CYC (`PFS_HEAT_US * `PFS_CYC_PER_US)
`define PFS_RUN_LIMIT_S 600
`define PFS_RUN_LIMIT_CYC (64'(`PFS_RUN_LIMIT_S) * 64'(`PFS_CLK_HZ))
`define PFS_BACK_LONG 10
`define PFS_BACK_SHORT 4
`define PFS_PAT0 4'h3
`define PFS_PAT1 4'h6
`define PFS_PAT2 4'hC
`define PFS_PAT3 4'h9
`endif

// file: hdl/pfs_pkg.sv
package pfs_pkg;
	typedef enum logic [1:0] {
		PFS_MODE_FEED,
		PFS_MODE_AUTO,
		PFS_MODE_PRINT,
		PFS_MODE_SLOW
	} pfs_mode_t;
	typedef enum logic [2:0] {
		PFS_ST_OFF,
		PFS_ST_WAKE,
		PFS_ST_BACK_REV,
		PFS_ST_BACK_FWD,
		PFS_ST_RUN,
		PFS_ST_STOP
	} pfs_state_t;
endpackage

// file: hdl/pfs_step_timer.sv
`timescale 1ns/1ps
`default_nettype none
// step period down-counter, preloads while idle
module pfs_step_timer #(
	parameter int PW = 32
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic [PW-1:0] period_i,
	output logic tick_o
);
	logic [PW-1:0] count;
	wire [PW-1:0] reload = period_i - PW'(1);

	assign tick_o = run_i && (count == '0);

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count <= '0;
		end else if (!run_i || tick_o) begin
			count <= reload;
		end else begin
			count <= count - PW'(1);
		end
	end
endmodule
`default_nettype wire

// file: hdl/pfs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfs_cfg.svh"
module pfs_sequencer import pfs_pkg::*; #(
	parameter int PW = 32,
	parameter int LW = 16,
	parameter logic [PW-1:0] FEED_CYC = PW'(`PFS_FEED_CYC),
	parameter logic [PW-1:0] AUTO_CYC = PW'(`PFS_AUTO_CYC),
	parameter logic [PW-1:0] SLOW_CYC = PW'(`PFS_SLOW_CYC),
	parameter logic [PW-1:0] HEAT_CYC = PW'(`PFS_HEAT_CYC),
	parameter logic [63:0] RUN_LIMIT_CYC = `PFS_RUN_LIMIT_CYC,
	parameter logic [LW-1:0] BACK_LONG = LW'(`PFS_BACK_LONG),
	parameter logic [LW-1:0] BACK_SHORT = LW'(`PFS_BACK_SHORT)
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic cmd_valid_i,
	input wire pfs_mode_t cmd_mode_i,
	input wire logic [LW-1:0] cmd_lines_i,
	input wire logic backlash_long_i,
	input wire logic [PW-1:0] print_period_i,
	input wire logic paper_present_i,
	input wire logic head_up_i,
	output logic cmd_ready_o,
	output logic busy_o,
	output logic done_o,
	output logic fault_o,
	output logic phase_a_o,
	output logic phase_b_o,
	output logic phase_a_bar_o,
	output logic phase_b_bar_o,
	output logic excitation_gate_o,
	output logic low_current_o
);
	pfs_state_t state, next_state;
	pfs_mode_t mode;
	wire [1:0] pin_s;
	logic [1:0] idx;
	logic [3:0] pattern;
	logic [LW-1:0] steps_left, lines;
	logic [63:0] run_cnt;
	logic back_long, fault, done, gate, low_cur;
	logic tick;

	// two-flop synchronisers for the sensor pins
	wire [1:0] pin_raw = {head_up_i, paper_present_i};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			logic s1, s2;
			always_ff @(posedge ref_clk_i or posedge rst_i) begin
				if (rst_i) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
				end else begin
					s1 <= pin_raw[gi];
					s2 <= s1;
				end
			end
			assign pin_s[gi] = s2;
		end
	endgenerate
	wire paper_s = pin_s[0];
	wire head_up_s = pin_s[1];

	// command accept and period selection
	wire in_off = (state == PFS_ST_OFF);
	wire in_stop = (state == PFS_ST_STOP);
	wire accept = cmd_valid_i && cmd_ready_o;
	wire pfs_mode_t sel_mode = accept ? cmd_mode_i : mode;
	wire [PW-1:0] sel_period = (sel_mode == PFS_MODE_FEED) ? FEED_CYC :
		(sel_mode == PFS_MODE_AUTO) ? AUTO_CYC :
		(sel_mode == PFS_MODE_PRINT) ? print_period_i : SLOW_CYC;
	wire [LW-1:0] back_lines = back_long ? BACK_LONG : BACK_SHORT;

	// step decode
	wire paper_ok = paper_s || head_up_s || (mode == PFS_MODE_AUTO);
	wire moving = (state == PFS_ST_BACK_REV) || (state == PFS_ST_BACK_FWD) ||
		(state == PFS_ST_RUN);
	wire last = (steps_left == '0);
	wire run_over = !in_off && (run_cnt >= RUN_LIMIT_CYC);
	// no step on the edge that de-excites, keeps the stored phase true
	wire step = tick && moving && !last && paper_ok && !run_over;
	wire step_rev = step && (state == PFS_ST_BACK_REV);
	wire paper_abort = tick && moving && !last && !paper_ok;
	wire [1:0] next_idx = step_rev ? idx - 2'd1 : (step ? idx + 2'd1 : idx);
	wire [3:0] next_pattern = (next_idx == 2'd0) ? `PFS_PAT0 :
		(next_idx == 2'd1) ? `PFS_PAT1 :
		(next_idx == 2'd2) ? `PFS_PAT2 : `PFS_PAT3;
	wire entering = (next_state != state);
	wire [LW-1:0] next_steps = !entering ? (step ? steps_left - LW'(1) : steps_left) :
		(next_state == PFS_ST_RUN) ? (accept ? cmd_lines_i : lines) : back_lines;
	wire next_low = (next_state != PFS_ST_OFF) && ((sel_period > HEAT_CYC) ||
		((sel_mode == PFS_MODE_PRINT) && (print_period_i > FEED_CYC)));

	always_comb begin
		next_state = state;
		case (state)
			PFS_ST_OFF: begin
				if (accept) begin
					next_state = PFS_ST_WAKE;
				end
			end
			PFS_ST_WAKE: begin
				if (tick) begin
					next_state = back_long ? PFS_ST_BACK_REV : PFS_ST_BACK_FWD;
				end
			end
			PFS_ST_BACK_REV: begin
				if (tick && last) begin
					next_state = PFS_ST_BACK_FWD;
				end
			end
			PFS_ST_BACK_FWD: begin
				if (tick && last) begin
					next_state = PFS_ST_RUN;
				end
			end
			PFS_ST_RUN: begin
				if (tick && last) begin
					next_state = PFS_ST_STOP;
				end
			end
			PFS_ST_STOP: begin
				if (accept) begin
					next_state = PFS_ST_RUN;
				end else if (tick) begin
					next_state = PFS_ST_OFF;
				end
			end
			default: begin
				next_state = PFS_ST_OFF;
			end
		endcase
		if (paper_abort) begin
			next_state = PFS_ST_STOP;
		end
		if (run_over) begin
			next_state = PFS_ST_OFF;
		end
	end

	pfs_step_timer #(
		.PW(PW)
	) u_timer (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.run_i(!in_off),
		.period_i(sel_period),
		.tick_o(tick)
	);

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= PFS_ST_OFF;
			mode <= PFS_MODE_FEED;
			lines <= '0;
			back_long <= 1'b1;
		end else begin
			state <= next_state;
			mode <= sel_mode;
			if (accept) begin
				lines <= cmd_lines_i;
				back_long <= backlash_long_i;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			idx <= 2'd0;
			pattern <= `PFS_PAT0;
			steps_left <= '0;
		end else begin
			idx <= next_idx;
			pattern <= next_pattern;
			steps_left <= next_steps;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			run_cnt <= '0;
			gate <= 1'b0;
			low_cur <= 1'b0;
			done <= 1'b0;
			fault <= 1'b0;
		end else begin
			run_cnt <= (next_state == PFS_ST_OFF) ? '0 : run_cnt + 64'd1;
			gate <= (next_state != PFS_ST_OFF);
			low_cur <= next_low;
			done <= !in_off && (next_state == PFS_ST_OFF);
			fault <= (paper_abort || run_over) ? 1'b1 : (accept ? 1'b0 : fault);
		end
	end

	assign cmd_ready_o = in_off || in_stop;
	assign busy_o = !in_off;
	assign done_o = done;
	assign fault_o = fault;
	assign {phase_a_o, phase_b_o, phase_a_bar_o, phase_b_bar_o} = pattern;
	assign excitation_gate_o = gate;
	assign low_current_o = low_cur;

	// checking helpers
	logic [PW-1:0] gap;
	logic [LW-1:0] rev_cnt;
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			gap <= '0;
			rev_cnt <= '0;
		end else begin
			gap <= step ? PW'(1) : gap + PW'(1);
			rev_cnt <= in_off ? '0 : rev_cnt + LW'(step_rev);
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	two_phase_a: assert property ($countones(pattern) == 2)
		else $error("phase pattern not two-on");
	phase_walk_a: assert property ($changed(idx) |->
		(idx == $past(idx) + 2'd1) || (idx == $past(idx) - 2'd1))
		else $error("phase index jumped");
	no_paper_step_a: assert property ($changed(idx) |-> $past(paper_ok))
		else $error("step without paper");
	wake_phase_a: assert property ((state == PFS_ST_WAKE) && $past(in_off) |->
		$stable(idx) && gate)
		else $error("restart changed phase");
	back_count_a: assert property ((state == PFS_ST_BACK_REV) ##1
		(state == PFS_ST_BACK_FWD) |-> rev_cnt == BACK_LONG)
		else $error("reverse backlash count wrong");
	feed_gap_a: assert property (step && (state == PFS_ST_RUN) &&
		(mode == PFS_MODE_FEED) |-> gap >= FEED_CYC)
		else $error("feed step too early");
	auto_low_a: assert property ((sel_mode == PFS_MODE_AUTO) &&
		(next_state != PFS_ST_OFF) |=> low_current_o)
		else $error("auto feed not current limited");
	stop_hold_a: assert property (in_stop |-> ##1 $stable(idx))
		else $error("stopping step moved");
	gate_off_a: assert property (in_off && !accept |=> !excitation_gate_o)
		else $error("gate high while idle");
	run_limit_a: assert property (run_cnt <= RUN_LIMIT_CYC)
		else $error("runtime limit passed");

	restart_c: cover property (in_stop && accept);
	backlash_c: cover property ((state == PFS_ST_BACK_FWD) ##1 (state == PFS_ST_RUN));
	auto_c: cover property (step && (mode == PFS_MODE_AUTO));
	abort_c: cover property (paper_abort);
endmodule
`default_nettype wire

// file: sim/pfs_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
// bipolar driver and feed motor, tracks paper position in dot lines
module pfs_motor_model (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic phase_a_i,
	input wire logic phase_b_i,
	input wire logic phase_a_bar_i,
	input wire logic phase_b_bar_i,
	input wire logic gate_i,
	input wire logic low_current_i,
	output logic signed [15:0] pos_o,
	output logic [31:0] gap_o,
	output logic lc_o,
	output logic bad_o
);
	logic [3:0] pat;
	logic [1:0] idx, last_idx;
	logic legal, gate_q;
	logic [31:0] cnt;
	assign pat = {phase_a_i, phase_b_i, phase_a_bar_i, phase_b_bar_i};
	assign legal = (pat == 4'h3) || (pat == 4'h6) || (pat == 4'hC) || (pat == 4'h9);
	assign idx = (pat == 4'h6) ? 2'h1 : (pat == 4'hC) ? 2'h2 : (pat == 4'h9) ? 2'h3 : 2'h0;
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pos_o <= '0;
			gap_o <= '0;
			lc_o <= 1'b0;
			bad_o <= 1'b0;
			gate_q <= 1'b0;
			cnt <= '0;
			last_idx <= 2'h0;
		end else begin
			gate_q <= gate_i;
			cnt <= cnt + 32'h1;
			if (gate_i && !legal) begin
				bad_o <= 1'b1;
			end
			if (gate_i && !gate_q && idx != last_idx) begin
				bad_o <= 1'b1;
			end
			if (gate_i && gate_q && legal && idx != last_idx) begin
				cnt <= '0;
				gap_o <= cnt + 32'h1;
				lc_o <= low_current_i;
				last_idx <= idx;
				if (idx == last_idx + 2'h1) begin
					pos_o <= pos_o + 16'sh1;
				end else if (idx == last_idx - 2'h1) begin
					pos_o <= pos_o - 16'sh1;
				end else begin
					bad_o <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: sim/paper_feed_stepper_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define PFS_CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
	$display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end
module paper_feed_stepper_sequencer_tb_top import pfs_pkg::*;;
	typedef struct {logic signed [15:0] pos; logic f; logic lc; logic [31:0] gap; logic c;} pfs_note_t;
	pfs_note_t notes[$];
	logic ref_clk_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0, backlash_long_i = 1'b0;
	pfs_mode_t cmd_mode_i = PFS_MODE_FEED;
	logic [15:0] cmd_lines_i = 16'h0;
	logic [31:0] print_period_i = 32'h14, gap;
	logic paper_present_i = 1'b0, head_up_i = 1'b0, lc_m, bad;
	logic cmd_ready_o, busy_o, done_o, fault_o, pa, pb, pab, pbb, gate, lc;
	logic signed [15:0] pos, exp_pos = 16'sh0;
	int num_errors = 0, compares = 0, seed = 32'hFAA1, p;
	initial forever #2.5 ref_clk_i = ~ref_clk_i;
	pfs_sequencer #(.FEED_CYC(32'h14), .AUTO_CYC(32'h28), .SLOW_CYC(32'h28), .HEAT_CYC(32'h1E),
		.RUN_LIMIT_CYC(64'h1388)) u_dut (.ref_clk_i, .rst_i, .cmd_valid_i, .cmd_mode_i,
		.cmd_lines_i, .backlash_long_i, .print_period_i, .paper_present_i, .head_up_i,
		.cmd_ready_o, .busy_o, .done_o, .fault_o, .phase_a_o(pa), .phase_b_o(pb),
		.phase_a_bar_o(pab), .phase_b_bar_o(pbb), .excitation_gate_o(gate), .low_current_o(lc));
	pfs_motor_model u_motor (.ref_clk_i, .rst_i, .phase_a_i(pa), .phase_b_i(pb),
		.phase_a_bar_i(pab), .phase_b_bar_i(pbb), .gate_i(gate), .low_current_i(lc), .pos_o(pos),
		.gap_o(gap), .lc_o(lc_m), .bad_o(bad));
	task automatic report_and_stop();
		if (notes.size() != 0) begin
			num_errors++;
			$display("Error at %0t: %0d results never seen", $time, notes.size());
		end
		$display("comparisons %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// drive one command and note what the motor should have done at its end
	task automatic run(input pfs_mode_t m, input logic [15:0] n, input logic lng, input logic pap,
		input logic hd, input logic [31:0] per, input logic signed [15:0] d, input logic f,
		input logic l, input logic [31:0] g, input logic c);
		int k;
		@(negedge ref_clk_i);
		paper_present_i = pap;
		head_up_i = hd;
		print_period_i = per;
		repeat (3) @(negedge ref_clk_i);
		for (k = 0; k < 100 && cmd_ready_o !== 1'b1; k++) @(negedge ref_clk_i);
		if (cmd_ready_o !== 1'b1) begin
			num_errors++;
			$display("Error at %0t: not ready", $time);
			report_and_stop();
		end
		cmd_mode_i = m;
		cmd_lines_i = n;
		backlash_long_i = lng;
		cmd_valid_i = 1'b1;
		exp_pos = exp_pos + d;
		notes.push_back('{exp_pos, f, l, g, c});
		@(negedge ref_clk_i);
		cmd_valid_i = 1'b0;
		for (k = 0; k < 20000 && done_o !== 1'b1; k++) @(negedge ref_clk_i);
		if (k == 20000) begin
			num_errors++;
			$display("Error at %0t: no done", $time);
			report_and_stop();
		end
		if (!c) exp_pos = pos;
		$display("test mode %0d lines %0d ended", m, n);
	endtask
	// checker side: oldest note against the motor at each done pulse
	always @(negedge ref_clk_i) begin
		pfs_note_t e;
		if (done_o === 1'b1) begin
			if (notes.size() == 0) begin
				num_errors++;
				$display("Error at %0t: unexpected done", $time);
			end else begin
				e = notes.pop_front();
				`PFS_CHK(fault_o, e.f)
				`PFS_CHK(gate, 1'b0)
				`PFS_CHK(busy_o, 1'b0)
				`PFS_CHK(cmd_ready_o, 1'b1)
				`PFS_CHK(bad, 1'b0)
				if (e.c) `PFS_CHK(pos, e.pos)
				if (e.gap != 32'h0) begin
					`PFS_CHK(gap, e.gap)
					`PFS_CHK(lc_m, e.lc)
				end
			end
		end
	end
	initial begin
		repeat (3) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		rst_i = 1'b0;
		run(PFS_MODE_FEED, 16'h5, 1'b1, 1'b1, 1'b0, 32'h14, 16'sh5, 1'b0, 1'b0, 32'h14, 1'b1);
		run(PFS_MODE_AUTO, 16'h3, 1'b0, 1'b0, 1'b0, 32'h14, 16'sh7, 1'b0, 1'b1, 32'h28, 1'b1);
		run(PFS_MODE_FEED, 16'h4, 1'b0, 1'b0, 1'b0, 32'h14, 16'sh0, 1'b1, 1'b0, 32'h0, 1'b1);
		run(PFS_MODE_FEED, 16'h2, 1'b0, 1'b0, 1'b1, 32'h14, 16'sh6, 1'b0, 1'b0, 32'h14, 1'b1);
		run(PFS_MODE_SLOW, 16'h2, 1'b1, 1'b1, 1'b0, 32'h14, 16'sh2, 1'b0, 1'b1, 32'h28, 1'b1);
		for (int i = 0; i < 3; i++) begin
			p = 5 + int'($unsigned($random(seed)) % 24);
			run(PFS_MODE_PRINT, 16'h3, 1'b1, 1'b1, 1'b0, 32'(p), 16'sh3, 1'b0, p > 20, 32'(p), 1'b1);
		end
		run(PFS_MODE_FEED, 16'h12C, 1'b1, 1'b1, 1'b0, 32'h14, 16'sh0, 1'b1, 1'b0, 32'h0, 1'b0);
		@(negedge ref_clk_i);
		report_and_stop();
	end
endmodule
`default_nettype wire
